/* sas_pkg.sv */
//==============================================================
// Function
// - eight pin channels, one routed to converter
// - store result, then flag or request
// - status/control write starts a conversion
// - selected pin forced to converter input
// - port writes ignored on selected pin
// - port read of selected pin gives zero
// - high reference gives ff, low 00
// - conversion takes 16 to 17 converter clocks
// - continuous flag stays set until write/read
// - select one sends request to dma
// - with enable set, shared bit only selects
// - keeps converting in wait, request wakes
// - stop mode aborts, resumes after exit
// - five-bit channel field, codes 0-7 pins
// - all-ones channel field powers converter off
// - prescaler divides 1,2,4,8, or 16
// - input clock select, oscillator after reset
`default_nettype none

package sas_pkg;
  //============================================================
  // widths and field layout of the control byte
  localparam int NUM_CH      = 8;   // shared port pins
  localparam int RES_W       = 8;   // result width
  localparam int CH_W        = 5;   // channel select width
  localparam int DIV_W       = 3;   // prescaler field width
  localparam int POS_FLAG    = 7;   // done flag / dma select
  localparam int POS_IEN     = 6;   // request enable
  localparam int POS_CONT    = 5;   // continuous mode
  localparam int POS_CH_HI   = 4;   // channel field top bit
  //============================================================
  // reset values
  localparam logic [CH_W-1:0]  CH_RESET   = 5'h1f; // powered off
  localparam logic [CH_W-1:0]  CH_OFF     = 5'h1f;
  localparam logic [DIV_W-1:0] DIV_RESET  = 3'h0;
  localparam logic             ICLK_RESET = 1'b0;  // oscillator
  //============================================================
  // timing: sixteen converter clocks, two per bit trial
  localparam int          CONV_TICKS = 16;
  localparam logic [3:0]  LAST_TICK  = 4'(CONV_TICKS - 1);

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,   // waiting for a start
    ST_CONV = 3'b010,   // approximation running
    ST_OFF  = 3'b100    // powered down
  } sas_state_type;
endpackage : sas_pkg

`default_nettype wire

/* sas_clk_if.sv */
`default_nettype none

//==============================================================
// carrier between sequencer and prescaler
interface sas_clk_if;
  logic [2:0] div;      // prescaler field
  logic       iclk;     // 1 = bus clock, 0 = oscillator
  logic       osc_sync; // oscillator level, already synchronised
  logic       restart;  // clear the prescaler count
  logic       tick;     // one converter clock, one cycle wide

  modport seq (output div, iclk, osc_sync, restart, input tick);
  modport pre (input div, iclk, osc_sync, restart, output tick);
endinterface : sas_clk_if

`default_nettype wire

/* sas_prescaler.sv */
`default_nettype none

module sas_prescaler
  import sas_pkg::*;
(
  input  wire logic clk,      // bus clock
  input  wire logic srst,     // synchronous reset
  sas_clk_if.pre    cif       // control and tick
);
  //============================================================
  // divide ratio minus one, top bit forces sixteen
  function automatic logic [3:0] ratio_m1(input logic [2:0] d);
    if (d[2])
      ratio_m1 = 4'hf;
    else
      ratio_m1 = 4'((5'h01 << d[1:0]) - 5'h01);
  endfunction

  logic       osc_prev;       // last oscillator level
  logic       next_osc_prev;
  logic [3:0] cnt;            // source edges counted
  logic [3:0] next_cnt;
  logic       tick;           // registered tick
  logic       next_tick;
  logic       src;            // one source edge this cycle

  //============================================================
  // source pick, count, and tick
  always_comb
  begin
    next_osc_prev = cif.osc_sync;
    // oscillator must run well below the bus clock
    src           = cif.iclk ? 1'b1
                             : (cif.osc_sync & ~osc_prev);
    next_cnt      = cnt;
    next_tick     = 1'b0;
    if (cif.restart)
      next_cnt = 4'h0;        // aligns the first tick
    else if (src)
    begin
      if (cnt >= ratio_m1(cif.div))
      begin
        next_cnt  = 4'h0;
        next_tick = 1'b1;
      end
      else
        next_cnt = cnt + 4'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      osc_prev <= 1'b0;
      cnt      <= 4'h0;
      tick     <= 1'b0;
    end
    else
    begin
      osc_prev <= next_osc_prev;
      cnt      <= next_cnt;
      tick     <= next_tick;
    end
  end

  assign cif.tick = tick;
endmodule : sas_prescaler

`default_nettype wire

/* sar_adc_sequencer.sv */
`default_nettype none

module sar_adc_sequencer
  import sas_pkg::*;
(
  input  wire logic               clk,          // bus clock, 50 MHz
  input  wire logic               srst,         // sync reset, high
  input  wire logic               scr_wr,       // status/control write
  input  wire logic [7:0]         scr_wdata,    // write data
  output logic      [7:0]         scr_rdata,    // status/control value
  input  wire logic               clkr_wr,      // clock register write
  input  wire logic [3:0]         clkr_wdata,   // {iclk, div[2:0]}
  output logic      [3:0]         clkr_rdata,   // clock register value
  input  wire logic               result_rd,    // result register read
  output logic      [RES_W-1:0]   result,       // last result
  input  wire logic               osc_clk_in,   // oscillator, async
  input  wire logic               stop_mode,    // stop mode level
  input  wire logic               cmp_high,     // input >= dac, async
  output logic      [RES_W-1:0]   dac_code,     // trial code to dac
  output logic      [2:0]         mux_sel,      // analog mux channel
  output logic                    mux_en,       // mux connects a pin
  output logic                    conv_power,   // analog powered
  output logic                    sample,       // hold input sample
  output logic                    conv_done,    // end pulse
  output logic                    cpu_irq,      // processor request
  output logic                    dma_req,      // dma request
  input  wire logic [NUM_CH-1:0]  port_out,     // port data drive
  input  wire logic [NUM_CH-1:0]  port_oe,      // port direction
  input  wire logic [NUM_CH-1:0]  pin_in,       // pin levels, async
  output logic      [NUM_CH-1:0]  pin_out,      // pin drive value
  output logic      [NUM_CH-1:0]  pin_oe,       // pin drive enable
  output logic      [NUM_CH-1:0]  port_rdata    // port read value
);
  //============================================================
  // synchronisers for the asynchronous inputs
  logic [NUM_CH-1:0] pin_s1, pin_s2;    // pin levels
  logic              cmp_s1, cmp_s2;    // comparator
  logic              osc_s1, osc_s2;    // oscillator

  always_ff @(posedge clk)
  begin
    pin_s1 <= pin_in;
    pin_s2 <= pin_s1;
    cmp_s1 <= cmp_high;
    cmp_s2 <= cmp_s1;
    osc_s1 <= osc_clk_in;
    osc_s2 <= osc_s1;
  end

  //============================================================
  // control state
  logic             flag, next_flag;       // done or dma select
  logic             ien, next_ien;         // request enable
  logic             cont, next_cont;       // continuous mode
  logic [CH_W-1:0]  ch, next_ch;           // channel field
  logic [DIV_W-1:0] div, next_div;         // prescaler field
  logic             iclk, next_iclk;       // input clock select
  logic             irq, next_irq;         // request pending
  logic             resume, next_resume;   // restart after stop
  sas_state_type    state, next_state;     // sequencer state
  logic [3:0]       step, next_step;       // tick within conversion
  logic [RES_W-1:0] sar, next_sar;         // approximation register
  logic [RES_W-1:0] res, next_res;         // result register
  logic             done, next_done;       // end pulse
  logic             off;                   // field says powered off
  logic             pin_ch;                // field names a pin
  logic             start;                 // begin a conversion
  logic             fin;                   // last tick of conversion
  logic [2:0]       bitn;                  // bit under trial
  logic             clr;                   // read or write clears

  sas_clk_if cif ();                       // prescaler link

  sas_prescaler u_pre
  (
    .clk  (clk),
    .srst (srst),
    .cif  (cif)
  );

  assign cif.div      = div;
  assign cif.iclk     = iclk;
  assign cif.osc_sync = osc_s2;
  assign cif.restart  = start;             // 16-17 tick spread

  //============================================================
  // decode of the selected channel
  always_comb
  begin
    off    = (ch == CH_OFF);
    pin_ch = (ch[POS_CH_HI:3] == 2'b00);   // codes 0..7
    bitn   = 3'(3'h7 - step[3:1]);
    fin    = (state == ST_CONV) && cif.tick && (step == LAST_TICK);
    clr    = scr_wr | result_rd;
    // a write restarts unless it selects off; stop blocks every start
    // the write path judges the new field, so a write wakes an off block
    start  = !stop_mode &&
             (scr_wr ? (scr_wdata[CH_W-1:0] != CH_OFF)
                     : (!off && ((fin && cont) ||
                                 (resume && state == ST_IDLE))));
  end

  //============================================================
  // register writes, flag and request
  always_comb
  begin
    next_ien    = ien;
    next_cont   = cont;
    next_ch     = ch;
    next_div    = div;
    next_iclk   = iclk;
    next_flag   = flag;
    next_irq    = irq;
    next_resume = resume;
    if (clkr_wr)
    begin
      next_div  = clkr_wdata[DIV_W-1:0];
      next_iclk = clkr_wdata[3];
    end
    if (scr_wr)
    begin
      next_ien  = scr_wdata[POS_IEN];
      next_cont = scr_wdata[POS_CONT];
      next_ch   = scr_wdata[CH_W-1:0];
      next_irq  = 1'b0;
      // writable select only while requests enabled
      next_flag = scr_wdata[POS_IEN] & scr_wdata[POS_FLAG];
    end
    else if (result_rd)
    begin
      next_irq = 1'b0;
      if (!ien)
        next_flag = 1'b0;
    end
    // completion wins over a clear in the same cycle
    if (done)
    begin
      if (ien)
        next_irq = 1'b1;
      else
        next_flag = 1'b1;
    end
    // remember a conversion cut off by stop mode
    if (stop_mode && (state == ST_CONV || cont))
      next_resume = 1'b1;
    else if (!stop_mode && state == ST_IDLE)
      next_resume = 1'b0;
    if (scr_wr)
      next_resume = 1'b0;
  end

  //============================================================
  // approximation sequencer
  always_comb
  begin
    next_state = state;
    next_step  = step;
    next_sar   = sar;
    next_res   = res;
    next_done  = 1'b0;
    case (state)
      ST_IDLE, ST_OFF:
      begin
        next_state = off ? ST_OFF : ST_IDLE;
        if (start)
        begin
          next_state = ST_CONV;
          next_step  = 4'h0;
          next_sar   = 8'h00;
        end
      end
      ST_CONV:
      begin
        if (stop_mode || off)
          next_state = off ? ST_OFF : ST_IDLE;
        else if (scr_wr)
        begin
          // a write at the last tick still abandons, no end pulse
          next_step  = 4'h0;
          next_sar   = 8'h00;
          next_state = start ? ST_CONV : ST_IDLE;
        end
        else if (cif.tick)
        begin
          // even tick puts the trial bit, odd tick judges it
          if (!step[0])
            next_sar[bitn] = 1'b1;
          else if (!cmp_s2)
            next_sar[bitn] = 1'b0;       // input below trial
          if (fin)
          begin
            next_res  = {sar[7:1], step[0] ? cmp_s2 : sar[0]};
            next_done = 1'b1;
            next_step = 4'h0;
            next_sar  = 8'h00;
            next_state = (cont && !stop_mode) ? ST_CONV
                                              : ST_IDLE;
          end
          else
            next_step = step + 4'h1;
        end
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      flag   <= 1'b0;
      ien    <= 1'b0;
      cont   <= 1'b0;
      ch     <= CH_RESET;
      div    <= DIV_RESET;
      iclk   <= ICLK_RESET;
      irq    <= 1'b0;
      resume <= 1'b0;
      state  <= ST_OFF;
      step   <= 4'h0;
      sar    <= 8'h00;
      res    <= 8'h00;
      done   <= 1'b0;
    end
    else
    begin
      flag   <= next_flag;
      ien    <= next_ien;
      cont   <= next_cont;
      ch     <= next_ch;
      div    <= next_div;
      iclk   <= next_iclk;
      irq    <= next_irq;
      resume <= next_resume;
      state  <= next_state;
      step   <= next_step;
      sar    <= next_sar;
      res    <= next_res;
      done   <= next_done;
    end
  end

  //============================================================
  // outputs; wait mode needs nothing, the request itself wakes
  logic [NUM_CH-1:0] sel_mask;   // one-hot of the pin in use

  always_comb
  begin
    sel_mask = '0;
    if (pin_ch && !off)
      sel_mask[ch[2:0]] = 1'b1;
  end

  assign scr_rdata  = {flag, ien, cont, ch};
  assign clkr_rdata = {iclk, div};
  assign result     = res;
  assign dac_code   = sar;
  assign mux_sel    = ch[2:0];
  assign mux_en     = pin_ch && !off;
  assign conv_power = !off && !stop_mode;
  assign sample     = (state == ST_CONV) && (step == 4'h0);
  assign conv_done  = done;
  assign cpu_irq    = irq & ien & ~flag;
  assign dma_req    = irq & ien & flag;
  assign pin_out    = port_out & ~sel_mask;
  assign pin_oe     = port_oe & ~sel_mask;
  assign port_rdata = pin_s2 & ~sel_mask;
endmodule : sar_adc_sequencer

`default_nettype wire

/* sas_analog_model.sv */
`default_nettype none
//============================================================
// comparator behind the analog mux
module sas_analog_model
  import sas_pkg::*;
(
  input  wire logic [63:0]      vin,        // levels, byte per pin
  input  wire logic             clk,        // bus clock
  input  wire logic [RES_W-1:0] dac_code,   // trial code
  input  wire logic [2:0]       mux_sel,    // channel
  input  wire logic             mux_en,     // pin connected
  input  wire logic             conv_power, // analog powered
  output logic                  cmp_high    // level >= trial
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wander = 1'b0; // unpowered output is noise, not a held 0
  //============================================================
  // noise source for an unpowered comparator
  always_ff @(posedge clk)
  begin
    wander <= ~wander;
  end
  // code equals level: top gives ff, bottom 00, linear between
  assign cmp_high = (conv_power && mux_en) ?
    (vin[{mux_sel, 3'h0} +: 8] >= dac_code) : wander;
endmodule // sas_analog_model
`default_nettype wire

/* sas_props.sv */
`default_nettype none
//============================================================
// port checker for the sequencer
module sas_props
  import sas_pkg::*;
(
  input wire logic              clk,        // bus clock
  input wire logic              srst,       // sync reset
  input wire logic              scr_wr,     // control write
  input wire logic [7:0]        scr_wdata,  // write data
  input wire logic [7:0]        scr_rdata,  // control value
  input wire logic              result_rd,  // result read
  input wire logic              stop_mode,  // stop level
  input wire logic              conv_power, // analog on
  input wire logic              sample,     // step 0
  input wire logic              conv_done,  // end pulse
  input wire logic              cpu_irq,    // cpu request
  input wire logic              dma_req,    // dma request
  input wire logic [2:0]        mux_sel,    // channel
  input wire logic              mux_en,     // pin taken
  input wire logic [NUM_CH-1:0] port_oe,    // port direction
  input wire logic [NUM_CH-1:0] pin_oe,     // pin enable
  input wire logic [NUM_CH-1:0] port_rdata  // port read
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  //============================================================
  // pin ownership
  property p_release;
    pin_oe == (port_oe & ~(mux_en ? (8'h01 << mux_sel) : 8'h00));
  endproperty
  a_release: assert property (p_release)
    else $error("port drive leaks onto taken pin");
  property p_read_zero;
    mux_en |-> !port_rdata[mux_sel];
  endproperty
  a_read_zero: assert property (p_read_zero)
    else $error("taken pin reads nonzero");
  //============================================================
  // start and end of conversion
  property p_start;
    scr_wr && scr_wdata[4:0] != 5'h1f && !stop_mode |=> sample;
  endproperty
  a_start: assert property (p_start)
    else $error("write did not start");
  property p_not_early;
    scr_wr |=> !conv_done [*8];
  endproperty
  a_not_early: assert property (p_not_early)
    else $error("conversion ended too soon");
  property p_flag;
    conv_done && !scr_rdata[6] && !scr_wr |=> scr_rdata[7];
  endproperty
  a_flag: assert property (p_flag)
    else $error("done flag not set");
  // the next conversion is already at step 0 when the end pulse shows
  property p_cont;
    conv_done && scr_rdata[5] |-> sample;
  endproperty
  a_cont: assert property (p_cont)
    else $error("continuous mode stalled");
  //============================================================
  // requests
  sequence s_req_end;
    conv_done && scr_rdata[6] && !scr_wr;
  endsequence
  property p_cpu;
    s_req_end ##0 !scr_rdata[7] |=> cpu_irq && !dma_req;
  endproperty
  a_cpu: assert property (p_cpu)
    else $error("cpu request missing");
  property p_dma;
    s_req_end ##0 scr_rdata[7] |=> dma_req && !cpu_irq;
  endproperty
  a_dma: assert property (p_dma)
    else $error("dma request missing");
  property p_clear;
    result_rd && !conv_done |=> !cpu_irq && !dma_req;
  endproperty
  a_clear: assert property (p_clear)
    else $error("request survived result read");
  property p_off;
    scr_rdata[4:0] == 5'h1f || stop_mode |-> !conv_power;
  endproperty
  a_off: assert property (p_off)
    else $error("converter powered when off");
  c_dma: cover property (conv_done ##1 dma_req);
  c_cont: cover property (conv_done && scr_rdata[5]);
  c_stop: cover property (stop_mode && $fell(conv_power));
endmodule // sas_props

bind sar_adc_sequencer sas_props u_props
(
  .clk(clk), .srst(srst), .scr_wr(scr_wr), .scr_wdata(scr_wdata),
  .scr_rdata(scr_rdata), .result_rd(result_rd), .stop_mode(stop_mode),
  .conv_power(conv_power), .sample(sample), .conv_done(conv_done),
  .cpu_irq(cpu_irq), .dma_req(dma_req), .mux_sel(mux_sel),
  .mux_en(mux_en), .port_oe(port_oe), .pin_oe(pin_oe),
  .port_rdata(port_rdata)
);
`default_nettype wire

/* sar_adc_sequencer_tb.sv */
`default_nettype none
//============================================================
// self-checking bench for the sequencer
module sar_adc_sequencer_tb;
  import sas_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, srst = 1, scr_wr = 0, clkr_wr = 0, result_rd = 0;
  logic osc_clk_in = 0, stop_mode = 0, cmp_high, mux_en, conv_power;
  logic sample, conv_done, cpu_irq, dma_req;
  logic [7:0] scr_wdata = 0, scr_rdata, result, dac_code;
  logic [3:0] clkr_wdata = 0, clkr_rdata;
  logic [2:0] mux_sel;
  logic [7:0] port_out = 8'ha5, port_oe = 8'hff, pin_in = 8'hff;
  logic [7:0] pin_out, pin_oe, port_rdata;
  logic [63:0] vin = 64'h13c4807f5a01ff00; // ch7..ch0 levels
  int err_count = 0, num_checks = 0, n;
  sar_adc_sequencer dut_u (.clk(clk), .srst(srst), .scr_wr(scr_wr),
    .scr_wdata(scr_wdata), .scr_rdata(scr_rdata), .clkr_wr(clkr_wr),
    .clkr_wdata(clkr_wdata), .clkr_rdata(clkr_rdata), .result(result),
    .result_rd(result_rd), .osc_clk_in(osc_clk_in), .sample(sample),
    .stop_mode(stop_mode), .cmp_high(cmp_high), .dac_code(dac_code),
    .mux_sel(mux_sel), .mux_en(mux_en), .conv_power(conv_power),
    .conv_done(conv_done), .cpu_irq(cpu_irq), .dma_req(dma_req),
    .port_out(port_out), .port_oe(port_oe), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .port_rdata(port_rdata));
  sas_analog_model ana_u (.vin(vin), .clk(clk), .dac_code(dac_code),
    .mux_sel(mux_sel), .mux_en(mux_en), .conv_power(conv_power),
    .cmp_high(cmp_high));
  //============================================================
  // clocks: oscillator slow, its edges on falling bus edges, off the rising ones
  initial forever #10 clk = ~clk;
  initial forever #80 osc_clk_in = ~osc_clk_in;
  //============================================================
  // helpers; outputs are read at edges, before they update
  task automatic fail(input string m);
    err_count++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask
  task automatic chk(input logic [7:0] got, exp, input string m);
    num_checks++;
    if (got !== exp)
      fail($sformatf("%s got %h exp %h", m, got, exp));
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wr_scr(input logic [7:0] d);
    @(posedge clk);
    scr_wr <= 1;
    scr_wdata <= d;
    @(posedge clk);
    scr_wr <= 0;
  endtask
  task automatic wr_clk(input logic [3:0] d);
    @(posedge clk);
    clkr_wr <= 1;
    clkr_wdata <= d;
    @(posedge clk);
    clkr_wr <= 0;
  endtask
  task automatic rd_res;
    result_rd <= 1;
    step(1);
    result_rd <= 0;
    step(1);
  endtask
  // bounded wait for the end pulse, n = edges taken
  task automatic wait_done(output int n);
    n = 0;
    do
    begin
      step(1);
      n++;
    end while (conv_done !== 1'b1 && n < 600);
    if (n >= 600)
      fail("no conversion end");
  endtask
  // no end pulse may appear for k cycles
  task automatic quiet(input int k);
    repeat (k)
    begin
      step(1);
      chk({7'h0, conv_done}, 8'h00, "unexpected end");
    end
  endtask
  function automatic logic [7:0] lvl(input int ch);
    return vin[ch*8 +: 8];
  endfunction
  // convert on ch with ratio r, check value and duration
  task automatic conv(input logic [7:0] d, input int r);
    wr_scr(d);
    wait_done(n);
    chk(result, lvl(d[2:0]), "result");
    chk({7'h0, n >= 16*r && n <= 17*r+4}, 8'h01, "time");
  endtask
  //============================================================
  // test sequence
  initial
  begin
    step(8);
    srst <= 0;
    step(2);
    chk(scr_rdata, 8'h1f, "scr reset");
    chk({4'h0, clkr_rdata}, 8'h00, "clk reset");
    chk({7'h0, conv_power}, 8'h00, "power at reset");
    wr_clk(4'ha);
    step(1);
    chk({4'h0, clkr_rdata}, 8'h0a, "clk reg");
    $display("test reset done");
    for (int ch = 0; ch < 8; ch++)
    begin
      conv(8'(ch), 4);
      chk({4'h0, mux_en, mux_sel}, 8'(8 + ch), "mux");
      chk(pin_oe, 8'hff & ~(8'h01 << ch), "pin oe");
      chk(pin_out, 8'ha5 & ~(8'h01 << ch), "pin out");
      chk(port_rdata, 8'hff & ~(8'h01 << ch), "port read");
      step(1);
      chk({7'h0, scr_rdata[7]}, 8'h01, "flag set");
      rd_res;
      chk({7'h0, scr_rdata[7]}, 8'h00, "flag cleared");
    end
    $display("test channels done");
    wr_clk(4'hb);
    conv(8'h03, 8);
    wr_clk(4'hc);
    conv(8'h05, 16);
    wr_clk(4'h0);
    wr_scr(8'h04);
    wait_done(n);
    chk(result, lvl(4), "osc result");
    wr_clk(4'ha);
    $display("test prescaler done");
    wr_scr(8'h42);
    wait_done(n);
    step(1);
    chk({6'h0, cpu_irq, dma_req}, 8'h02, "cpu req");
    chk({7'h0, scr_rdata[7]}, 8'h00, "select only");
    step(3);
    chk({7'h0, cpu_irq}, 8'h01, "req held");
    rd_res;
    chk({7'h0, cpu_irq}, 8'h00, "req cleared");
    wr_scr(8'hc5);
    wait_done(n);
    step(1);
    chk({6'h0, cpu_irq, dma_req}, 8'h01, "dma req");
    chk(scr_rdata, 8'hc5, "select kept");
    wr_scr(8'h05);
    step(1);
    chk({7'h0, dma_req}, 8'h00, "dma cleared");
    $display("test requests done");
    wr_scr(8'h00);
    step(30);
    conv(8'h06, 4);
    $display("test restart done");
    wr_scr(8'h21);
    wait_done(n);
    chk(result, 8'hff, "cont first");
    vin[15:8] <= 8'h3c;
    wait_done(n);
    wait_done(n);
    chk(result, 8'h3c, "cont overwrite");
    step(1);
    chk({7'h0, scr_rdata[7]}, 8'h01, "cont flag");
    wr_scr(8'h01);
    wait_done(n);
    quiet(120);
    $display("test continuous done");
    wr_scr(8'h07);
    step(20);
    stop_mode <= 1;
    quiet(100);
    chk({7'h0, conv_power}, 8'h00, "stop power");
    stop_mode <= 0;
    wait_done(n);
    chk(result, lvl(7), "resume");
    // analog side has had a full conversion to settle now
    conv(8'h07, 4);
    wr_scr(8'h1f);
    quiet(200);
    chk({7'h0, conv_power}, 8'h00, "off power");
    $display("test low power done");
    tally_and_finish;
  end
  // hang guard, far beyond the few thousand cycles needed
  initial
  begin
    step(20000);
    fail("watchdog");
    tally_and_finish;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
endmodule // sar_adc_sequencer_tb
`default_nettype wire
